// >>> hw/scs_line_conv.sv
`timescale 1ns/100ps
`include "scs_params.svh"

// Converts one measured input to its A-B line-to-line equivalent
module scs_line_conv (
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic [15:0] mag_in,
  input  wire logic [15:0] angle_in,
  input  wire logic        neutral_in,
  output logic [15:0]      line_mag_out,
  output logic [15:0]      line_angle_out
);

  scs_pkg::scs_conv_state_t cur_reg;
  scs_pkg::scs_conv_state_t cur_next;
  logic [26:0]              prod;

  assign prod = 27'(mag_in) * `SCS_SQRT3_NUM;

  always_comb begin
    cur_next = cur_reg;
    if (neutral_in) begin
      // A-N phasor scaled by root three, advanced 30 degrees
      cur_next.mag   = (|prod[26:26]) ? 16'hffff : prod[25:10];
      cur_next.angle = angle_in + `SCS_ANGLE_30DEG;
    end else begin
      cur_next.mag   = mag_in;
      cur_next.angle = angle_in;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cur_reg <= '0;
    end else begin
      cur_reg <= cur_next;
    end
  end

  assign line_mag_out   = cur_reg.mag;
  assign line_angle_out = cur_reg.angle;

endmodule

// >>> hw/scs_params.svh
`ifndef SCS_PARAMS_SVH
`define SCS_PARAMS_SVH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SCS_CLK_MHZ          125
`define SCS_TICK_MS          1
`define SCS_TICK_CYCLES      (`SCS_TICK_MS * 1000 * `SCS_CLK_MHZ)
`define SCS_FAIL_PULSE_MS    200
`define SCS_TIMEOUT_UNIT_MS  20'h00064

// ----------------------------------------------------------------
// Arithmetic constants
// ----------------------------------------------------------------
`define SCS_SQRT3_NUM        27'h00006ed
`define SCS_SQRT3_SHIFT      10
`define SCS_ANGLE_30DEG      16'h1555
`define SCS_LEAD_NUM         34'h0000010c7
`define SCS_LEAD_SHIFT       16
`define SCS_FREQ_MIN_MHZ     16'hb3b0
`define SCS_FREQ_MAX_MHZ     16'hfa00

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define SCS_OFF_CTRL         8'h00
`define SCS_OFF_DEAD         8'h04
`define SCS_OFF_LIVE         8'h08
`define SCS_OFF_DF           8'h0c
`define SCS_OFF_DV           8'h10
`define SCS_OFF_ANG          8'h14
`define SCS_OFF_CB           8'h18
`define SCS_OFF_TIMEOUT      8'h1c
`define SCS_OFF_STATUS       8'h20
`define SCS_OFF_MASK         8'h24
`define SCS_OFF_STATE        8'h28

// ----------------------------------------------------------------
// Control fields and status layout
// ----------------------------------------------------------------
`define SCS_CTRL_SMODE_LSB   0
`define SCS_CTRL_VMODE_LSB   2
`define SCS_CTRL_PAIR_BIT    5
`define SCS_CTRL_REFN_BIT    6
`define SCS_CTRL_YN_BIT      7
`define SCS_CTRL_ZN_BIT      8
`define SCS_ST_CLOSE_LSB     0
`define SCS_ST_FAIL_LSB      2

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SCS_RST_CTRL         9'h008
`define SCS_RST_DEAD         16'h00c8
`define SCS_RST_LIVE         16'h0320
`define SCS_RST_DF           10'h032
`define SCS_RST_DV           16'h0064
`define SCS_RST_ANG          16'h0e39
`define SCS_RST_CB           10'h064
`define SCS_RST_TIMEOUT      13'h0064

`endif

// >>> hw/scs_pkg.sv
package scs_pkg;

  typedef enum logic [1:0] {
    SCS_SMODE_OFF,
    SCS_SMODE_WINDOW,
    SCS_SMODE_ZERO
  } scs_smode_t;

  typedef enum logic [1:0] {
    SCS_ST_IDLE,
    SCS_ST_WAIT,
    SCS_ST_FAIL
  } scs_stage_st_t;

  typedef struct packed {
    logic [15:0] mag;
    logic [15:0] angle;
  } scs_conv_state_t;

  typedef struct packed {
    scs_stage_st_t st;
    logic [19:0]   ms_cnt;
    logic          close;
    logic [15:0]   prev_pred;
  } scs_stage_t;

  typedef struct packed {
    logic [8:0]        ctrl;
    logic [15:0]       dead_lim;
    logic [15:0]       live_lim;
    logic [9:0]        df_lim;
    logic [15:0]       dv_lim;
    logic [15:0]       ang_lim;
    logic [9:0]        cb_ms;
    logic [12:0]       timeout;
    logic [3:0]        status;
    logic [3:0]        mask;
    logic [31:0]       rdata;
    logic [16:0]       ms_div;
    scs_stage_t [1:0]  stage;
  } scs_top_state_t;

endpackage

// >>> hw/scs_top.sv
`timescale 1ns/100ps
`include "scs_params.svh"

// How it works
// R1 - Synchronism always uses the A-B line voltage, derived from A-N when needed.
// R2 - Stage one compares reference line voltage with second-side line voltage.
// R3 - Stage two compares reference/second side or second/third side, selectable.
// R4 - Neutral second and third inputs are converted to A-B line equivalents.
// R5 - Mode off: only the dead/live voltage criterion decides synchronism.
// R6 - Window mode: all three criteria; close aimed at entering angle limit.
// R7 - Zero mode: all three criteria; close aimed at zero phase difference.
// R8 - Close is advanced by a lead from slip and breaker closing time.
// R9 - Voltage code: first letter reference side, second letter comparison side.
// R10 - Dead side qualifies only below the dead-voltage limit.
// R11 - Live side qualifies only above the live-voltage limit.
// R12 - Request output stands from start until synchronism or timeout.
// R13 - Timeout without synchronism gives a fixed 200 ms fail pulse.
// R14 - Bypass input skips all checks and declares synchronism.
// R15 - Frequency/phase checking needs both sides live and all differences in limit.
// R16 - Combined voltage selection is met when any listed pair is met.
// R17 - OK output follows synchronism combinationally, regardless of requests.
module scs_top #(
  parameter int TICK_CYCLES   = `SCS_TICK_CYCLES,
  parameter int FAIL_PULSE_MS = `SCS_FAIL_PULSE_MS
) (
  input  wire logic        MCLK_IN,
  input  wire logic        RST_N_IN,
  input  wire logic [7:0]  REG_ADDR_IN,
  input  wire logic [31:0] REG_WDATA_IN,
  input  wire logic        REG_WR_IN,
  input  wire logic        REG_RD_IN,
  output logic [31:0]      REG_RDATA_OUT,
  input  wire logic [15:0] REF_MAG_IN,
  input  wire logic [15:0] REF_FREQ_IN,
  input  wire logic [15:0] REF_ANGLE_IN,
  input  wire logic [15:0] SECOND_MAG_IN,
  input  wire logic [15:0] SECOND_FREQ_IN,
  input  wire logic [15:0] SECOND_ANGLE_IN,
  input  wire logic [15:0] THIRD_MAG_IN,
  input  wire logic [15:0] THIRD_FREQ_IN,
  input  wire logic [15:0] THIRD_ANGLE_IN,
  input  wire logic [1:0]  CLOSE_REQ_IN,
  input  wire logic [1:0]  BYPASS_IN,
  output logic [1:0]       REQUEST_OUT,
  output logic [1:0]       OK_OUT,
  output logic [1:0]       FAIL_OUT,
  output logic [1:0]       CLOSE_CMD_OUT,
  output logic             IRQ_OUT
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  localparam scs_pkg::scs_top_state_t RST_STATE = '{
    ctrl:     `SCS_RST_CTRL,
    dead_lim: `SCS_RST_DEAD,
    live_lim: `SCS_RST_LIVE,
    df_lim:   `SCS_RST_DF,
    dv_lim:   `SCS_RST_DV,
    ang_lim:  `SCS_RST_ANG,
    cb_ms:    `SCS_RST_CB,
    timeout:  `SCS_RST_TIMEOUT,
    default:  '0
  };

  scs_pkg::scs_top_state_t cur_reg;
  scs_pkg::scs_top_state_t cur_next;

  logic [15:0]      in_mag   [3];
  logic [15:0]      in_angle [3];
  logic [15:0]      in_freq  [3];
  logic [2:0]       in_neut;
  logic [15:0]      line_mag   [3];
  logic [15:0]      line_angle [3];
  logic [1:0]       smode;
  logic [2:0]       vmode;
  logic             pair_yz;
  logic             tick;
  logic [19:0]      timeout_ms;
  logic [1:0]       sync_met;
  logic [15:0]      pred [2];

  assign smode   = cur_reg.ctrl[`SCS_CTRL_SMODE_LSB +: 2];
  assign vmode   = cur_reg.ctrl[`SCS_CTRL_VMODE_LSB +: 3];
  assign pair_yz = cur_reg.ctrl[`SCS_CTRL_PAIR_BIT];
  assign in_neut = {cur_reg.ctrl[`SCS_CTRL_ZN_BIT], cur_reg.ctrl[`SCS_CTRL_YN_BIT],
                    cur_reg.ctrl[`SCS_CTRL_REFN_BIT]};

  assign in_mag[0]   = REF_MAG_IN;
  assign in_mag[1]   = SECOND_MAG_IN;
  assign in_mag[2]   = THIRD_MAG_IN;
  assign in_angle[0] = REF_ANGLE_IN;
  assign in_angle[1] = SECOND_ANGLE_IN;
  assign in_angle[2] = THIRD_ANGLE_IN;
  assign in_freq[0]  = REF_FREQ_IN;
  assign in_freq[1]  = SECOND_FREQ_IN;
  assign in_freq[2]  = THIRD_FREQ_IN;

  assign tick       = cur_reg.ms_div == 17'(TICK_CYCLES - 1);
  assign timeout_ms = 20'(cur_reg.timeout) * `SCS_TIMEOUT_UNIT_MS;

  // ----------------------------------------------------------------
  // Line-to-line equivalents of all three inputs
  // ----------------------------------------------------------------
  for (genvar c = 0; c < 3; c++) begin : g_conv
    scs_line_conv u_conv (
      .clk_in         (MCLK_IN),
      .rst_n_in       (RST_N_IN),
      .mag_in         (in_mag[c]),
      .angle_in       (in_angle[c]),
      .neutral_in     (in_neut[c]),          // see R1
      .line_mag_out   (line_mag[c]),
      .line_angle_out (line_angle[c])        // see R4
    );
  end

  // ----------------------------------------------------------------
  // Per-stage synchronism evaluation
  // ----------------------------------------------------------------
  for (genvar s = 0; s < 2; s++) begin : g_stage
    logic [1:0]  ia;
    logic [1:0]  ib;
    logic        vmet;
    logic        both_live;
    logic [16:0] slip;
    logic [16:0] slip_abs;
    logic        slip_ok;
    logic [15:0] dv;
    logic        dv_ok;
    logic        freq_ok;
    logic [33:0] lead_prod;
    logic [15:0] lead_mag;
    logic [15:0] lead;
    logic [15:0] phase;
    logic [15:0] pred_abs;
    logic        in_win;
    logic        zero_cross;
    logic        fp_met;

    // Stage one fixed; stage two selectable pair
    assign ia = (s == 1 && pair_yz) ? 2'h1 : 2'h0;  // see R2, R3
    assign ib = (s == 1 && pair_yz) ? 2'h2 : 2'h1;  // see R3

    scs_volt_check u_vchk (
      .ref_mag_in    (line_mag[ia]),
      .cmp_mag_in    (line_mag[ib]),
      .dead_lim_in   (cur_reg.dead_lim),
      .live_lim_in   (cur_reg.live_lim),
      .vmode_in      (vmode),
      .vmet_out      (vmet),
      .both_live_out (both_live)
    );

    assign slip     = {1'b0, in_freq[ia]} - {1'b0, in_freq[ib]};
    assign slip_abs = slip[16] ? 17'(-slip) : slip;
    assign slip_ok  = slip_abs <= 17'(cur_reg.df_lim);
    assign dv       = (line_mag[ia] > line_mag[ib]) ? line_mag[ia] - line_mag[ib]
                                                     : line_mag[ib] - line_mag[ia];
    assign dv_ok    = dv <= cur_reg.dv_lim;
    assign freq_ok  = in_freq[ia] >= `SCS_FREQ_MIN_MHZ && in_freq[ia] <= `SCS_FREQ_MAX_MHZ &&
                      in_freq[ib] >= `SCS_FREQ_MIN_MHZ && in_freq[ib] <= `SCS_FREQ_MAX_MHZ;

    // Angle travelled during breaker closing time
    assign lead_prod = 34'(slip_abs[9:0]) * 34'(cur_reg.cb_ms) * `SCS_LEAD_NUM;  // see R8
    assign lead_mag  = (|lead_prod[33:32]) ? 16'hffff : lead_prod[31:16];
    assign lead      = slip[16] ? 16'(-lead_mag) : lead_mag;                      // see R8

    assign phase    = line_angle[ia] - line_angle[ib];
    assign pred[s]  = phase + lead;
    assign pred_abs = pred[s][15] ? 16'(-pred[s]) : pred[s];
    assign in_win   = pred_abs <= cur_reg.ang_lim;                                // see R6
    assign zero_cross = (pred[s] == 16'h0000) ||
                        (pred[s][15] != cur_reg.stage[s].prev_pred[15]);          // see R7

    assign fp_met = both_live & slip_ok & dv_ok & freq_ok & in_win &              // see R15
                    ((smode == 2'(scs_pkg::SCS_SMODE_ZERO)) ? zero_cross : 1'b1); // see R6, R7

    assign sync_met[s] = BYPASS_IN[s] |                                           // see R14
                         ((smode == 2'(scs_pkg::SCS_SMODE_WINDOW) ||
                           smode == 2'(scs_pkg::SCS_SMODE_ZERO)) ? fp_met : vmet); // see R5
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [3:0] set_ev;
    set_ev   = 4'h0;
    cur_next = cur_reg;

    cur_next.ms_div = tick ? 17'h00000 : cur_reg.ms_div + 17'h00001;

    for (int s = 0; s < 2; s++) begin
      cur_next.stage[s].close     = 1'b0;
      cur_next.stage[s].prev_pred = pred[s];
      unique case (cur_reg.stage[s].st)
        scs_pkg::SCS_ST_IDLE: begin
          if (CLOSE_REQ_IN[s]) begin
            cur_next.stage[s].st     = scs_pkg::SCS_ST_WAIT;  // see R12
            cur_next.stage[s].ms_cnt = 20'h00000;
          end
        end
        scs_pkg::SCS_ST_WAIT: begin
          if (sync_met[s]) begin
            cur_next.stage[s].st    = scs_pkg::SCS_ST_IDLE;   // see R12
            cur_next.stage[s].close = 1'b1;
            set_ev[`SCS_ST_CLOSE_LSB + s] = 1'b1;
          end else if (cur_reg.stage[s].ms_cnt >= timeout_ms) begin
            cur_next.stage[s].st     = scs_pkg::SCS_ST_FAIL;  // see R13
            cur_next.stage[s].ms_cnt = 20'h00000;
            set_ev[`SCS_ST_FAIL_LSB + s] = 1'b1;
          end else if (tick) begin
            cur_next.stage[s].ms_cnt = cur_reg.stage[s].ms_cnt + 20'h00001;
          end
        end
        scs_pkg::SCS_ST_FAIL: begin
          if (cur_reg.stage[s].ms_cnt >= 20'(FAIL_PULSE_MS)) begin
            cur_next.stage[s].st = scs_pkg::SCS_ST_IDLE;      // see R13
          end else if (tick) begin
            cur_next.stage[s].ms_cnt = cur_reg.stage[s].ms_cnt + 20'h00001;
          end
        end
        default: begin
          cur_next.stage[s].st = scs_pkg::SCS_ST_IDLE;
        end
      endcase
    end

    // Register writes; new events win over a write-one clear
    cur_next.status = cur_reg.status | set_ev;
    if (REG_WR_IN) begin
      unique case (REG_ADDR_IN)
        `SCS_OFF_CTRL:    cur_next.ctrl     = REG_WDATA_IN[8:0];
        `SCS_OFF_DEAD:    cur_next.dead_lim = REG_WDATA_IN[15:0];
        `SCS_OFF_LIVE:    cur_next.live_lim = REG_WDATA_IN[15:0];
        `SCS_OFF_DF:      cur_next.df_lim   = REG_WDATA_IN[9:0];
        `SCS_OFF_DV:      cur_next.dv_lim   = REG_WDATA_IN[15:0];
        `SCS_OFF_ANG:     cur_next.ang_lim  = REG_WDATA_IN[15:0];
        `SCS_OFF_CB:      cur_next.cb_ms    = REG_WDATA_IN[9:0];
        `SCS_OFF_TIMEOUT: cur_next.timeout  = REG_WDATA_IN[12:0];
        `SCS_OFF_STATUS:  cur_next.status   = (cur_reg.status & ~REG_WDATA_IN[3:0]) | set_ev;
        `SCS_OFF_MASK:    cur_next.mask     = REG_WDATA_IN[3:0];
        default:          cur_next.ctrl     = cur_reg.ctrl;
      endcase
    end

    // Read data valid only in the cycle after the strobe
    cur_next.rdata = 32'h00000000;
    if (REG_RD_IN) begin
      unique case (REG_ADDR_IN)
        `SCS_OFF_CTRL:    cur_next.rdata = 32'(cur_reg.ctrl);
        `SCS_OFF_DEAD:    cur_next.rdata = 32'(cur_reg.dead_lim);
        `SCS_OFF_LIVE:    cur_next.rdata = 32'(cur_reg.live_lim);
        `SCS_OFF_DF:      cur_next.rdata = 32'(cur_reg.df_lim);
        `SCS_OFF_DV:      cur_next.rdata = 32'(cur_reg.dv_lim);
        `SCS_OFF_ANG:     cur_next.rdata = 32'(cur_reg.ang_lim);
        `SCS_OFF_CB:      cur_next.rdata = 32'(cur_reg.cb_ms);
        `SCS_OFF_TIMEOUT: cur_next.rdata = 32'(cur_reg.timeout);
        `SCS_OFF_STATUS:  cur_next.rdata = 32'(cur_reg.status);
        `SCS_OFF_MASK:    cur_next.rdata = 32'(cur_reg.mask);
        `SCS_OFF_STATE:   cur_next.rdata = 32'({FAIL_OUT, sync_met, REQUEST_OUT});
        default:          cur_next.rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      cur_reg <= RST_STATE;
    end else begin
      cur_reg <= cur_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  for (genvar s = 0; s < 2; s++) begin : g_out
    assign REQUEST_OUT[s]   = cur_reg.stage[s].st == scs_pkg::SCS_ST_WAIT;  // see R12
    assign FAIL_OUT[s]      = cur_reg.stage[s].st == scs_pkg::SCS_ST_FAIL;  // see R13
    assign CLOSE_CMD_OUT[s] = cur_reg.stage[s].close;
  end

  assign OK_OUT        = sync_met;  // see R17
  assign REG_RDATA_OUT = cur_reg.rdata;
  assign IRQ_OUT       = |(cur_reg.status & cur_reg.mask);

endmodule

// >>> hw/scs_volt_check.sv
`timescale 1ns/100ps

// Dead/live voltage criterion for one reference/comparison pair
module scs_volt_check (
  input  wire logic [15:0] ref_mag_in,
  input  wire logic [15:0] cmp_mag_in,
  input  wire logic [15:0] dead_lim_in,
  input  wire logic [15:0] live_lim_in,
  input  wire logic [2:0]  vmode_in,
  output logic             vmet_out,
  output logic             both_live_out
);

  logic ref_dead;
  logic ref_live;
  logic cmp_dead;
  logic cmp_live;

  assign ref_dead = ref_mag_in < dead_lim_in;  // see R10
  assign cmp_dead = cmp_mag_in < dead_lim_in;  // see R10
  assign ref_live = ref_mag_in > live_lim_in;  // see R11
  assign cmp_live = cmp_mag_in > live_lim_in;  // see R11

  // First letter reference side, second letter comparison side
  assign vmet_out = (vmode_in[0] & ref_dead & cmp_dead) |  // see R9
                    (vmode_in[1] & ref_dead & cmp_live) |  // see R16
                    (vmode_in[2] & ref_live & cmp_dead);   // see R16

  assign both_live_out = ref_live & cmp_live;

endmodule

// >>> tb/scs_breaker_model.sv
`timescale 1ns/100ps

// Object control: close request is go delayed by one cycle, counts breaker closes
module scs_breaker_model (
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic [1:0] go_in,
  input  wire logic [1:0] close_cmd_in,
  output logic      [1:0] close_req_out,
  output logic      [7:0] closes_out
);
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      close_req_out <= 2'h0;
      closes_out    <= 8'h00;
    end else begin
      close_req_out <= go_in;
      closes_out    <= closes_out + 8'(close_cmd_in[0]) + 8'(close_cmd_in[1]);
    end
  end
endmodule

// >>> tb/scs_top_monitor.sv
`timescale 1ns/100ps

module scs_top_monitor #(
  parameter int TICK_CYCLES   = 125000,
  parameter int FAIL_PULSE_MS = 200
) (
  input  wire logic        MCLK_IN,
  input  wire logic        RST_N_IN,
  input  wire logic        REG_RD_IN,
  input  wire logic [31:0] REG_RDATA_OUT,
  input  wire logic [1:0]  CLOSE_REQ_IN,
  input  wire logic [1:0]  BYPASS_IN,
  input  wire logic [1:0]  REQUEST_OUT,
  input  wire logic [1:0]  OK_OUT,
  input  wire logic [1:0]  FAIL_OUT,
  input  wire logic [1:0]  CLOSE_CMD_OUT
);
  localparam int FAIL_MIN = FAIL_PULSE_MS * TICK_CYCLES;
  localparam int FAIL_MAX = (FAIL_PULSE_MS + 2) * TICK_CYCLES;
  logic [31:0] fail_cnt_reg;
  logic [31:0] fail_cnt_next;
  always_comb fail_cnt_next = FAIL_OUT[0] ? fail_cnt_reg + 32'h1 : 32'h0;
  always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) fail_cnt_reg <= 32'h0;
    else fail_cnt_reg <= fail_cnt_next;
  end
  default clocking mon_cb @(posedge MCLK_IN); endclocking
  default disable iff (!RST_N_IN);
  sequence s_req_ok; REQUEST_OUT[0] && OK_OUT[0]; endsequence
  sequence s_close; CLOSE_CMD_OUT[0] && !REQUEST_OUT[0]; endsequence
  property p_bypass; (BYPASS_IN & ~OK_OUT) == 2'h0; endproperty
  property p_close_seq; s_req_ok |=> s_close ##1 !CLOSE_CMD_OUT[0]; endproperty
  property p_close_cause; (CLOSE_CMD_OUT & ~$past(REQUEST_OUT & OK_OUT)) == 2'h0; endproperty
  property p_req_start;
    (($past(CLOSE_REQ_IN & ~REQUEST_OUT & ~FAIL_OUT)) & ~REQUEST_OUT) == 2'h0;
  endproperty
  property p_req_hold; REQUEST_OUT[1] && !OK_OUT[1] |=> REQUEST_OUT[1] || FAIL_OUT[1]; endproperty
  property p_fail_entry;
    $rose(FAIL_OUT[0]) |-> $past(REQUEST_OUT[0]) && !REQUEST_OUT[0];
  endproperty
  property p_fail_len;
    (FAIL_OUT[0] |-> fail_cnt_reg <= FAIL_MAX) and ($fell(FAIL_OUT[0]) |-> fail_cnt_reg >= FAIL_MIN);
  endproperty
  property p_rd_zero; !$past(REG_RD_IN) |-> REG_RDATA_OUT == 32'h0; endproperty
  a_bypass: assert property (p_bypass) else $error("bypass without ok");
  a_close_seq: assert property (p_close_seq) else $error("close not issued after ok");
  a_close_cause: assert property (p_close_cause) else $error("close without ok request");
  a_req_start: assert property (p_req_start) else $error("request not started");
  a_req_hold: assert property (p_req_hold) else $error("request dropped early");
  a_fail_entry: assert property (p_fail_entry) else $error("fail without request");
  a_fail_len: assert property (p_fail_len) else $error("fail pulse length wrong");
  a_rd_zero: assert property (p_rd_zero) else $error("read data outside slot");
endmodule

bind scs_top scs_top_monitor #(.TICK_CYCLES(TICK_CYCLES), .FAIL_PULSE_MS(FAIL_PULSE_MS))
  scs_top_monitor_i (.MCLK_IN(MCLK_IN), .RST_N_IN(RST_N_IN), .REG_RD_IN(REG_RD_IN),
  .REG_RDATA_OUT(REG_RDATA_OUT), .CLOSE_REQ_IN(CLOSE_REQ_IN), .BYPASS_IN(BYPASS_IN),
  .REQUEST_OUT(REQUEST_OUT), .OK_OUT(OK_OUT), .FAIL_OUT(FAIL_OUT),
  .CLOSE_CMD_OUT(CLOSE_CMD_OUT));

// >>> tb/test_scs_top.sv
`timescale 1ns/100ps

module test_scs_top;
  localparam logic [15:0] DEAD = 16'h00c8;
  localparam logic [15:0] LIVE = 16'h0320;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        rd_seen = 1'b0;
  logic        irq;
  logic        exp_irq = 1'b0;
  logic [31:0] rdata;
  logic [15:0] rm = 16'h0, rf = 16'h0, sm = 16'h0, sf = 16'h0, sa = 16'h0, tm = 16'h0;
  logic [1:0]  bypass = 2'h0, go = 2'h0, creq, cmd, req, ok, fail;
  logic [7:0]  closes;
  logic [32:0] note_q [$];
  logic [32:0] note;
  int          n_mismatch = 0;
  int          samples_checked = 0;
  int          i;
  int          seed = 32'h72f5e736;
  logic [31:0] x, y;
  logic [15:0] lvl [6] = '{16'h00c7, 16'h00c8, 16'h00c9, 16'h031f, 16'h0320, 16'h0321};
  logic [31:0] rst_tab [12] = '{32'h008, 32'h0c8, 32'h320, 32'h032, 32'h064, 32'he39,
                                32'h064, 32'h064, 32'h0, 32'h0, 32'h0, 32'h0};
  logic [31:0] msk_tab [8] = '{32'h1ff, 32'hffff, 32'hffff, 32'h3ff, 32'hffff, 32'hffff,
                               32'h3ff, 32'h1fff};
  logic [80:0] fc [12] = '{
    {1'b1, 16'h0001, 16'h0384, 16'hc350, 16'hc350, 16'h0000},
    {1'b1, 16'h0001, 16'h0384, 16'hc350, 16'hc350, 16'h0e39},
    {1'b0, 16'h0001, 16'h0384, 16'hc350, 16'hc350, 16'h0e3a},
    {1'b0, 16'h0001, 16'h0384, 16'hc383, 16'hc350, 16'h0000},
    {1'b1, 16'h0001, 16'h0384, 16'hc382, 16'hc350, 16'h0000},
    {1'b0, 16'h0001, 16'h0384, 16'h9c40, 16'h9c40, 16'h0000},
    {1'b0, 16'h0001, 16'h0064, 16'hc350, 16'hc350, 16'h0000},
    {1'b0, 16'h0001, 16'h0320, 16'hc350, 16'hc350, 16'h0000},
    {1'b0, 16'h0001, 16'h03e9, 16'hc350, 16'hc350, 16'h0000},
    {1'b1, 16'h0002, 16'h0384, 16'hc350, 16'hc350, 16'h0000},
    {1'b0, 16'h0002, 16'h0384, 16'hc350, 16'hc350, 16'h0100},
    {1'b1, 16'h0010, 16'h0064, 16'h9c40, 16'h9c40, 16'h0000}};

  always #4 clk = ~clk;

  scs_top #(.TICK_CYCLES(10), .FAIL_PULSE_MS(20)) scs_top_i (
    .MCLK_IN(clk), .RST_N_IN(rst_n), .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata),
    .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdata), .REF_MAG_IN(rm),
    .REF_FREQ_IN(rf), .REF_ANGLE_IN(16'h0000), .SECOND_MAG_IN(sm), .SECOND_FREQ_IN(sf),
    .SECOND_ANGLE_IN(sa), .THIRD_MAG_IN(tm), .THIRD_FREQ_IN(16'h0000),
    .THIRD_ANGLE_IN(16'h0000), .CLOSE_REQ_IN(creq), .BYPASS_IN(bypass), .REQUEST_OUT(req),
    .OK_OUT(ok), .FAIL_OUT(fail), .CLOSE_CMD_OUT(cmd), .IRQ_OUT(irq));

  scs_breaker_model scs_breaker_model_i (.clk_in(clk), .rst_n_in(rst_n), .go_in(go),
    .close_cmd_in(cmd), .close_req_out(creq), .closes_out(closes));

  // Read result checker: interrupt line and read data against oldest note
  always @(posedge clk) rd_seen <= rd;
  always @(negedge clk) begin
    if (rd_seen === 1'b1) begin
      note = note_q.pop_front();
      samples_checked++;
      if ({irq, rdata} !== note) begin
        n_mismatch++;
        $display("BAD t=%0t got=%h exp=%h", $time, {irq, rdata}, note);
      end
    end
  end

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    note_q.push_back({exp_irq, e});
    @(posedge clk);
    rd <= 1'b0;
  endtask

  task automatic pulse_go(input logic [1:0] g);
    @(posedge clk);
    go <= g;
    @(posedge clk);
    go <= 2'h0;
    repeat (4) @(posedge clk);
  endtask

  function automatic logic vok(input logic [2:0] v, input logic [15:0] r, input logic [15:0] c);
    return (v[0] && r < DEAD && c < DEAD) || (v[1] && r < DEAD && c > LIVE) ||
           (v[2] && r > LIVE && c < DEAD);
  endfunction

  function automatic logic [15:0] pick(input logic [31:0] v);
    return (v[2:0] > 3'h5) ? v[31:16] : lvl[v[2:0]];
  endfunction

  task automatic finish_test();
    $display("mismatches %0d comparisons %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    #400000;
    n_mismatch++;
    finish_test();
  end

  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    for (i = 0; i < 12; i++) reg_rd(8'(i * 4), rst_tab[i]);
    for (i = 0; i < 8; i++) reg_wr(8'(i * 4), 32'hffffffff);
    for (i = 0; i < 8; i++) reg_rd(8'(i * 4), msk_tab[i]);
    for (i = 0; i < 8; i++) reg_wr(8'(i * 4), rst_tab[i]);
    reg_wr(8'h28, 32'hffffffff);
    reg_wr(8'h2c, 32'hffffffff);
    reg_rd(8'h28, 32'h0);
    reg_rd(8'h2c, 32'h0);
    $display("registers done");
    for (i = 0; i < 32; i++) begin
      x = $random(seed);
      y = $random(seed);
      rm <= pick(x);
      sm <= pick(y);
      tm <= pick($random(seed));
      reg_wr(8'h00, {26'h0, x[8], x[12:10], 2'h0});
      repeat (4) @(posedge clk);
      reg_rd(8'h28, {28'h0, x[8] ? vok(x[12:10], sm, tm) : vok(x[12:10], rm, sm),
                     vok(x[12:10], rm, sm), 2'h0});
    end
    rm <= 16'h0064;
    sm <= 16'h01f4;
    reg_wr(8'h00, 32'h008);
    reg_rd(8'h28, 32'h0);
    reg_wr(8'h00, 32'h088);
    repeat (4) @(posedge clk);
    reg_rd(8'h28, 32'h00c);
    $display("voltage criteria done");
    rm <= 16'h0384;
    for (i = 0; i < 12; i++) begin
      sm <= fc[i][63:48];
      sf <= fc[i][47:32];
      rf <= fc[i][31:16];
      sa <= fc[i][15:0];
      reg_wr(8'h00, 32'(fc[i][79:64]));
      repeat (4) @(posedge clk);
      reg_rd(8'h28, fc[i][80] ? 32'h00c : 32'h0);
    end
    $display("frequency and phase done");
    reg_wr(8'h24, 32'hf);
    reg_wr(8'h00, 32'h000);
    bypass <= 2'h1;
    pulse_go(2'h1);
    exp_irq = 1'b1;
    reg_rd(8'h28, 32'h004);
    reg_rd(8'h20, 32'h001);
    reg_wr(8'h20, 32'h001);
    exp_irq = 1'b0;
    reg_rd(8'h20, 32'h000);
    bypass <= 2'h0;
    rm <= 16'h0064;
    sm <= 16'h0384;
    reg_wr(8'h00, 32'h008);
    pulse_go(2'h2);
    exp_irq = 1'b1;
    reg_rd(8'h20, 32'h002);
    reg_wr(8'h20, 32'h002);
    exp_irq = 1'b0;
    reg_rd(8'h28, 32'h00c);
    $display("close done");
    rm <= 16'h0;
    sm <= 16'h0;
    reg_wr(8'h00, 32'h001);
    reg_wr(8'h1c, 32'h001);
    pulse_go(2'h1);
    reg_rd(8'h28, 32'h001);
    for (i = 0; i < 2000 && fail[0] !== 1'b1; i++) @(posedge clk);
    exp_irq = 1'b1;
    pulse_go(2'h1);
    reg_rd(8'h28, 32'h010);
    reg_rd(8'h20, 32'h004);
    reg_wr(8'h20, 32'h004);
    exp_irq = 1'b0;
    for (i = 0; i < 400 && fail[0] !== 1'b0; i++) @(posedge clk);
    reg_rd(8'h28, 32'h000);
    $display("timeout done");
    repeat (4) @(posedge clk);
    finish_test();
  end
endmodule
